// ==== hdl/ptb_pkg.sv ====
/*
  Constants for the packet to transaction bridge: codes, header layout,
  response layout and buffer sizing.
  Assumes an 8-bit packet stream in and out and a 32-bit memory master.
*/
package ptb_pkg;
  // ----------------------------------------------------------------
  // Transaction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] PTB_CODE_WR_FIXED = 8'h00;
  localparam logic [7:0] PTB_CODE_WR_INCR = 8'h04;
  localparam logic [7:0] PTB_CODE_RD_FIXED = 8'h10;
  localparam logic [7:0] PTB_CODE_RD_INCR = 8'h14;
  localparam logic [7:0] PTB_CODE_NOP = 8'h7F;
  localparam logic [7:0] PTB_RESP_FLIP = 8'h80;
  localparam logic [7:0] PTB_RSVD_BYTE = 8'h00;
  // ----------------------------------------------------------------
  // Header byte positions
  // ----------------------------------------------------------------
  localparam logic [3:0] PTB_POS_CODE = 4'h0;
  localparam logic [3:0] PTB_POS_SIZE_HI = 4'h2;
  localparam logic [3:0] PTB_POS_SIZE_LO = 4'h3;
  localparam logic [3:0] PTB_POS_ADDR_LAST = 4'h7;
  localparam logic [3:0] PTB_HDR_LEN = 4'h8;
  localparam logic [2:0] PTB_RESP_LEN = 3'h4;
  // ----------------------------------------------------------------
  // Sizing
  // ----------------------------------------------------------------
  localparam int PTB_FIFO_DEPTH = 32;
  localparam int PTB_SYM_W = 8;
  localparam int PTB_DATA_W = 32;
  localparam logic [31:0] PTB_WORD_STEP = 32'h0000_0004;
endpackage

// ==== hdl/ptb_bridge.sv ====
/*
  Packet to transaction bridge: request packets on an 8-bit stream sink
  become single-beat 32-bit reads and writes; responses leave on an 8-bit
  stream source through a small FIFO.
  Assumes one clock and one reset shared by stream and memory sides.
*/
// Summary of operation
// - Sink and source carry 8-bit symbols with sop/eop, no channel, ready latency zero
// - Master port is 32 bits wide, issues reads and writes, never bursts
// - No error signal is driven on either stream
// - Size counts data bytes for writes, bytes to fetch for reads
// - Write response: code with msb flipped, reserved, bytes written count
// - Exactly one response packet per completed write request
// - Code 0x7f starts no access yet returns a response packet
// - Unknown codes behave exactly like the no-operation code
// - Read response is the fetched data bytes only, no header
// - Code 0x00 writes one fixed word address until the byte with eop is written
// - Code 0x04 writes data to consecutive addresses from the given one
// - Code 0x10 reads one fixed address repeatedly until size bytes read
// - Code 0x14 reads size bytes from consecutive addresses
// - One transaction at a time; sink ready only when current one is done
// - Data passes straight through; waitrequest stalls the sink
// - While the response FIFO is full the read strobe stays low
// - After lost read data, return only data actually received
// - End of packet ends the data whatever the size field says
// - A mid-transaction start of packet aborts silently and starts a new parse
`timescale 1ns/100ps
module ptb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("ptb_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  logic full;
  logic empty;
  logic push;
  logic pop;
  assign full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  assign empty = (wr_ptr_ff == rd_ptr_ff);
  assign push = in_valid_in && !full;
  assign pop = out_ready_in && !empty;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_ff[rd_ptr_ff[AW-1:0]];
  // Storage array, no reset needed
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data_in;
    end
  end
  // Pointers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule

module ptb_bridge
  import ptb_pkg::*;
#(
  parameter int FIFO_DEPTH = PTB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Stream sink (requests)
  input wire logic snk_valid_in,
  input wire logic [7:0] snk_data_in,
  input wire logic snk_sop_in,
  input wire logic snk_eop_in,
  output logic snk_ready_out,
  // Stream source (responses)
  output logic src_valid_out,
  output logic [7:0] src_data_out,
  output logic src_sop_out,
  output logic src_eop_out,
  input wire logic src_ready_in,
  // Memory master
  output logic [31:0] mm_address_out,
  output logic mm_read_out,
  output logic mm_write_out,
  output logic [31:0] mm_writedata_out,
  output logic [3:0] mm_byteenable_out,
  input wire logic [31:0] mm_readdata_in,
  input wire logic mm_readdatavalid_in,
  input wire logic mm_waitrequest_in
);
  initial begin
    if (FIFO_DEPTH < 8) $error("ptb_bridge needs at least 8 response entries");
  end
  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_HDR = 6'b000001,
    ST_WDATA = 6'b000010,
    ST_WBUS = 6'b000100,
    ST_RBUS = 6'b001000,
    ST_RWAIT = 6'b010000,
    ST_RESP = 6'b100000
  } ptb_state_e;
  ptb_state_e state_ff;
  logic [3:0] hdr_pos_ff;
  logic [7:0] code_ff;
  logic [15:0] size_ff;
  logic [31:0] addr_ff;
  logic [15:0] done_ff;
  logic [31:0] wword_ff;
  logic [3:0] wbe_ff;
  logic last_ff;
  logic [2:0] resp_pos_ff;
  logic [1:0] rbyte_ff;
  logic [31:0] rword_ff;
  logic rvalid_ff;
  // FIFO links: {sop, eop, data}
  logic f_in_valid;
  logic [9:0] f_in_data;
  logic f_in_ready;
  logic f_out_valid;
  logic [9:0] f_out_data;
  logic is_write;
  logic is_read;
  logic is_fixed;
  logic take;
  logic wr_done;
  logic [15:0] rd_left;
  logic [1:0] boff;
  logic [15:0] byte_ofs;
  logic [31:0] word_addr;
  // ----------------------------------------------------------------
  // Decode and handshakes
  // ----------------------------------------------------------------
  assign is_write = (code_ff == PTB_CODE_WR_FIXED) || (code_ff == PTB_CODE_WR_INCR);
  assign is_read = (code_ff == PTB_CODE_RD_FIXED) || (code_ff == PTB_CODE_RD_INCR);
  assign is_fixed = (code_ff == PTB_CODE_WR_FIXED) || (code_ff == PTB_CODE_RD_FIXED);
  assign boff = addr_ff[1:0] + done_ff[1:0];
  assign rd_left = size_ff - done_ff;
  // Word holding the current byte: fixed codes stay put, others walk
  assign byte_ofs = done_ff + {14'h0, addr_ff[1:0]};
  assign word_addr = is_fixed ? {addr_ff[31:2], 2'b00}
                              : {addr_ff[31:2], 2'b00} + {16'h0, byte_ofs[15:2], 2'b00};
  // Sink beat is accepted only while parsing or collecting write data
  assign take = snk_valid_in && snk_ready_out;
  assign wr_done = mm_write_out && !mm_waitrequest_in;
  // Sink ready, registered; dropped the cycle after every accepted beat
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      snk_ready_out <= 1'b0;
    end else begin
      snk_ready_out <= ((state_ff == ST_HDR) || (state_ff == ST_WDATA)) && !take
                       || (state_ff == ST_WBUS && wr_done && !last_ff)
                       || (state_ff == ST_RESP && resp_pos_ff == PTB_RESP_LEN - 3'h1
                           && f_in_ready)
                       || (state_ff == ST_RWAIT && rvalid_ff && rbyte_ff == 2'h3
                           && f_in_ready && rd_left <= 16'h0001);
      if (take) snk_ready_out <= 1'b0;
      if (state_ff == ST_HDR && !take) snk_ready_out <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_HDR;
      hdr_pos_ff <= 4'h0;
      code_ff <= PTB_CODE_NOP;
      size_ff <= 16'h0000;
      addr_ff <= 32'h0000_0000;
      done_ff <= 16'h0000;
      wword_ff <= 32'h0000_0000;
      wbe_ff <= 4'h0;
      last_ff <= 1'b0;
      resp_pos_ff <= 3'h0;
      rbyte_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rword_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        ST_HDR: begin
          if (take) begin
            // Header bytes: code, reserved, size msb/lsb, address msb first
            if (snk_sop_in) begin  // New packet restarts the parse
              hdr_pos_ff <= 4'h1;
              code_ff <= snk_data_in;
            end else if (hdr_pos_ff != PTB_POS_CODE) begin
              hdr_pos_ff <= hdr_pos_ff + 4'h1;
            end
            if (hdr_pos_ff == PTB_POS_SIZE_HI) size_ff[15:8] <= snk_data_in;
            if (hdr_pos_ff == PTB_POS_SIZE_LO) size_ff[7:0] <= snk_data_in;
            if (hdr_pos_ff >= 4'h4) addr_ff <= {addr_ff[23:0], snk_data_in};
            done_ff <= 16'h0000;
            wbe_ff <= 4'h0;
            if (snk_sop_in || hdr_pos_ff == PTB_POS_CODE) begin
              // Stray bytes before any sop are ignored
            end else if (hdr_pos_ff == PTB_POS_ADDR_LAST || snk_eop_in) begin
              hdr_pos_ff <= 4'h0;
              if (is_read && !snk_eop_in) begin
                state_ff <= ST_HDR;  // Overridden below: reads go to ST_RBUS with or without eop
              end
              if (is_write && !snk_eop_in) state_ff <= ST_WDATA;
              else if (is_read) state_ff <= ST_RBUS;
              else resp_pos_ff <= 3'h0;
              if (!is_write && !is_read) state_ff <= ST_RESP;
              if (is_write && snk_eop_in) state_ff <= ST_RESP;
            end
          end
        end
        ST_WDATA: begin
          if (take && snk_sop_in) begin
            state_ff <= ST_HDR;  // Abort, no response
            hdr_pos_ff <= 4'h1;
            code_ff <= snk_data_in;
          end else if (take) begin
            // Pack the byte into its lane; go to the bus per byte
            wword_ff[boff*8 +: 8] <= snk_data_in;
            wbe_ff <= 4'h0;
            wbe_ff[boff] <= 1'b1;
            last_ff <= snk_eop_in;
            state_ff <= ST_WBUS;
          end
        end
        ST_WBUS: begin
          if (wr_done) begin
            done_ff <= done_ff + 16'h0001;
            state_ff <= last_ff ? ST_RESP : ST_WDATA;
            resp_pos_ff <= 3'h0;
          end
        end
        ST_RBUS: begin
          // Read strobe waits for room downstream
          if (mm_read_out && !mm_waitrequest_in) state_ff <= ST_RWAIT;
          rbyte_ff <= boff;
          if (rd_left == 16'h0000) state_ff <= ST_HDR;
        end
        ST_RWAIT: begin
          if (mm_readdatavalid_in) begin
            rword_ff <= mm_readdata_in;
            rvalid_ff <= 1'b1;
          end
          if (rvalid_ff) begin
            // Push fetched bytes only; a full FIFO drops the byte
            done_ff <= done_ff + 16'h0001;
            rbyte_ff <= rbyte_ff + 2'h1;
            if (rd_left <= 16'h0001) begin
              state_ff <= ST_HDR;
              rvalid_ff <= 1'b0;
            end else if (rbyte_ff == 2'h3) begin
              rvalid_ff <= 1'b0;
              state_ff <= ST_RBUS;
            end
          end
        end
        ST_RESP: begin
          if (f_in_ready) begin
            resp_pos_ff <= resp_pos_ff + 3'h1;
            if (resp_pos_ff == PTB_RESP_LEN - 3'h1) state_ff <= ST_HDR;
          end
        end
        default: state_ff <= ST_HDR;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Memory master outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mm_write_out <= 1'b0;
      mm_read_out <= 1'b0;
      mm_address_out <= 32'h0000_0000;
      mm_writedata_out <= 32'h0000_0000;
      mm_byteenable_out <= 4'h0;
    end else begin
      if (wr_done || (mm_read_out && !mm_waitrequest_in)) begin
        mm_write_out <= 1'b0;
        mm_read_out <= 1'b0;
      end else if (state_ff == ST_WBUS && !mm_write_out) begin
        mm_write_out <= 1'b1;  // Single beat, never a burst
        mm_writedata_out <= wword_ff;
        mm_byteenable_out <= wbe_ff;
        // Fixed code stays on one word, incrementing walks words
        mm_address_out <= word_addr;
      end else if (state_ff == ST_RBUS && !mm_read_out && rd_left != 16'h0000
                   && f_in_ready) begin
        mm_read_out <= 1'b1;  // Whole word read
        mm_byteenable_out <= 4'hF;
        mm_address_out <= word_addr;
      end
    end
  end
  // ----------------------------------------------------------------
  // Response byte generation into the FIFO
  // ----------------------------------------------------------------
  always_comb begin
    f_in_valid = 1'b0;
    f_in_data = 10'h000;
    if (state_ff == ST_RESP) begin
      f_in_valid = 1'b1;
      case (resp_pos_ff)
        3'h0: f_in_data = {1'b1, 1'b0, code_ff ^ PTB_RESP_FLIP};
        3'h1: f_in_data = {2'b00, PTB_RSVD_BYTE};
        3'h2: f_in_data = {2'b00, done_ff[15:8]};
        default: f_in_data = {1'b0, 1'b1, done_ff[7:0]};
      endcase
    end else if (state_ff == ST_RWAIT && rvalid_ff) begin
      f_in_valid = 1'b1;
      // Data only; sop on first byte, eop on last
      f_in_data = {done_ff == 16'h0000, rd_left <= 16'h0001, rword_ff[rbyte_ff*8 +: 8]};
    end
  end
  // Response buffer; source ready backpressures it
  ptb_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .in_valid_in(f_in_valid),
    .in_data_in(f_in_data),
    .in_ready_out(f_in_ready),
    .out_valid_out(f_out_valid),
    .out_data_out(f_out_data),
    .out_ready_in(src_ready_in && (!src_valid_out || src_ready_in))
  );
  // Source output register; no error signal exists on the port
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      src_valid_out <= 1'b0;
      src_data_out <= 8'h00;
      src_sop_out <= 1'b0;
      src_eop_out <= 1'b0;
    end else if (!src_valid_out || src_ready_in) begin
      src_valid_out <= f_out_valid && src_ready_in;
      src_sop_out <= f_out_data[9];
      src_eop_out <= f_out_data[8];
      src_data_out <= f_out_data[7:0];
    end
  end
endmodule

// ==== verification/ptb_bridge_assertions.sv ====
/*
  Port checker for ptb_bridge: strobe holding, stalls and response framing.
  Assumes it is bound to every ptb_bridge and sees only its ports.
*/
`timescale 1ns/100ps
module ptb_bridge_assertions (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Stream ports
  input wire logic snk_ready_out,
  input wire logic src_valid_out,
  input wire logic [7:0] src_data_out,
  input wire logic src_sop_out,
  input wire logic src_eop_out,
  input wire logic src_ready_in,
  // Memory ports
  input wire logic [31:0] mm_address_out,
  input wire logic mm_read_out,
  input wire logic mm_write_out,
  input wire logic [31:0] mm_writedata_out,
  input wire logic [3:0] mm_byteenable_out,
  input wire logic mm_waitrequest_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------------------------------
  // Source packet tracking and stall sequences
  // ----------------------------------------------------------------
  logic in_pkt_ff;
  // Set between an accepted first byte and an accepted last byte
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      in_pkt_ff <= 1'b0;
    end else if (src_valid_out && src_ready_in) begin
      in_pkt_ff <= !src_eop_out;
    end
  end
  sequence s_wr_stall; mm_write_out && mm_waitrequest_in; endsequence
  sequence s_rd_stall; mm_read_out && mm_waitrequest_in; endsequence
  sequence s_src_stall; src_valid_out && !src_ready_in; endsequence
  AST_NO_MIXED: assert property (!(mm_read_out && mm_write_out))
    else $error("read and write strobes together");
  AST_WR_HOLD: assert property (s_wr_stall |=> mm_write_out
    && $stable(mm_writedata_out) && $stable(mm_address_out))
    else $error("stalled write not held");
  AST_RD_HOLD: assert property (s_rd_stall |=> mm_read_out && $stable(mm_address_out))
    else $error("stalled read not held");
  AST_SRC_HOLD: assert property (s_src_stall |=> src_valid_out
    && $stable(src_data_out) && $stable(src_sop_out) && $stable(src_eop_out))
    else $error("stalled byte changed");
  AST_SNK_STALL: assert property (s_wr_stall |-> !snk_ready_out)
    else $error("sink ready during write stall");
  AST_RD_BUSY: assert property (mm_read_out |-> !snk_ready_out)
    else $error("sink ready during read");
  AST_ONE_LANE: assert property (mm_write_out |-> $onehot(mm_byteenable_out))
    else $error("write not one byte lane");
  AST_SOP_FIRST: assert property (src_valid_out && !in_pkt_ff |-> src_sop_out)
    else $error("first response byte lacks sop");
  AST_SOP_ONCE: assert property (src_valid_out && in_pkt_ff |-> !src_sop_out)
    else $error("sop inside response");
endmodule

bind ptb_bridge ptb_bridge_assertions chk (.clk_in, .rst_b_in, .snk_ready_out, .src_valid_out,
  .src_data_out, .src_sop_out, .src_eop_out, .src_ready_in, .mm_address_out, .mm_read_out,
  .mm_write_out, .mm_writedata_out, .mm_byteenable_out, .mm_waitrequest_in);

// ==== verification/ptb_mem_model.sv ====
/*
  Memory slave model: 16 words, byte lanes, read latency one cycle.
  Assumes the bench picks stall cycles through stall_in.
*/
`timescale 1ns/100ps
module ptb_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Slave side
  input wire logic [31:0] mm_address_in,
  input wire logic mm_read_in,
  input wire logic mm_write_in,
  input wire logic [31:0] mm_writedata_in,
  input wire logic [3:0] mm_byteenable_in,
  input wire logic stall_in,
  output logic [31:0] mm_readdata_out,
  output logic mm_readdatavalid_out,
  output logic mm_waitrequest_out
);
  logic [31:0] mem [16];
  int acc_cnt;
  logic [31:0] last_addr;
  // Stall straight from the bench knob
  assign mm_waitrequest_out = stall_in;
  // Single-beat accesses; idle read data toggles so it never looks valid
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < 64; i++) mem[i / 4][8 * (i % 4) +: 8] <= 8'(i) ^ 8'h5A;
      acc_cnt <= 0;
      last_addr <= 32'h0;
      mm_readdatavalid_out <= 1'b0;
      mm_readdata_out <= 32'hFFFF_FFFF;
    end else begin
      mm_readdatavalid_out <= 1'b0;
      mm_readdata_out <= ~mm_readdata_out;
      if ((mm_read_in || mm_write_in) && !stall_in) begin
        acc_cnt <= acc_cnt + 1;
        last_addr <= mm_address_in;
      end
      if (mm_write_in && !stall_in) begin
        for (int l = 0; l < 4; l++) begin
          if (mm_byteenable_in[l]) begin
            mem[mm_address_in[5:2]][8 * l +: 8] <= mm_writedata_in[8 * l +: 8];
          end
        end
      end
      if (mm_read_in && !stall_in) begin
        mm_readdatavalid_out <= 1'b1;
        mm_readdata_out <= mem[mm_address_in[5:2]];
      end
    end
  end
endmodule

// ==== verification/ptb_bridge_test.sv ====
/*
  Self-checking bench for ptb_bridge: packets in, responses and memory traffic out.
  Assumes ptb_mem_model as the slave and a random but seeded stall pattern.
*/
`timescale 1ns/100ps
module ptb_bridge_test;
  import ptb_pkg::*;
  localparam int LIM = 2000;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic snk_valid = 1'b0;
  logic snk_sop = 1'b0;
  logic snk_eop = 1'b0;
  logic [7:0] snk_data = 8'h00;
  logic src_ready = 1'b1;
  logic stall = 1'b0;
  logic rnd_on = 1'b0;
  wire logic snk_ready, src_valid, src_sop, src_eop, mm_rd, mm_wr, rdv, wreq;
  wire logic [7:0] src_data;
  wire logic [31:0] addr, wdata, rdata;
  wire logic [3:0] be;
  integer seed = 65;
  int num_errors = 0;
  int comparisons = 0;
  logic [9:0] rx_q[$];
  logic [9:0] exp_q[$];
  logic [7:0] sh[64];
  logic [7:0] wd[16];
  // ----------------------------------------------------------------
  // Clock, knobs, collector, instances
  // ----------------------------------------------------------------
  always #50 clk_in = ~clk_in;
  // Random backpressure on both sides once enabled
  always @(posedge clk_in) begin
    src_ready <= rnd_on ? 1'($random(seed)) : 1'b1;
    stall <= rnd_on ? 1'($random(seed)) : 1'b0;
  end
  // Collect every accepted response byte with its markers
  always @(posedge clk_in) begin
    if (src_valid === 1'b1 && src_ready === 1'b1) rx_q.push_back({src_sop, src_eop, src_data});
  end
  ptb_bridge #(.FIFO_DEPTH(PTB_FIFO_DEPTH)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .snk_valid_in(snk_valid), .snk_data_in(snk_data), .snk_sop_in(snk_sop),
    .snk_eop_in(snk_eop), .snk_ready_out(snk_ready), .src_valid_out(src_valid),
    .src_data_out(src_data), .src_sop_out(src_sop), .src_eop_out(src_eop),
    .src_ready_in(src_ready), .mm_address_out(addr), .mm_read_out(mm_rd),
    .mm_write_out(mm_wr), .mm_writedata_out(wdata), .mm_byteenable_out(be),
    .mm_readdata_in(rdata), .mm_readdatavalid_in(rdv), .mm_waitrequest_in(wreq));
  ptb_mem_model mem_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .mm_address_in(addr),
    .mm_read_in(mm_rd), .mm_write_in(mm_wr), .mm_writedata_in(wdata),
    .mm_byteenable_in(be), .stall_in(stall), .mm_readdata_out(rdata),
    .mm_readdatavalid_out(rdv), .mm_waitrequest_out(wreq));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    $display("ERROR t=%0t wait limit got=%h exp=%h", $time, 0, 1);
    wrap_up();
  endtask
  // One beat, held until the sink takes it
  task automatic put(input logic [7:0] d, input logic s, input logic e);
    int n;
    n = 0;
    snk_valid <= 1'b1;
    snk_data <= d;
    snk_sop <= s;
    snk_eop <= e;
    do begin
      @(posedge clk_in);
      n++;
    end while (snk_ready !== 1'b1 && n < LIM);
    if (n >= LIM) timeout();
  endtask
  // Request packet; hl below 8 cuts the header short with no end marker
  task automatic pkt(input logic [7:0] c, input int sz, input logic [31:0] a, input int nd,
                     input int hl);
    logic [7:0] h[8];
    h = '{c, 8'h00, 8'(sz >> 8), 8'(sz), a[31:24], a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < hl; i++) put(h[i], i == 0, i == 7 && nd == 0);
    for (int i = 0; i < nd; i++) put(wd[i], 1'b0, i == nd - 1);
    snk_valid <= 1'b0;
    @(posedge clk_in);
  endtask
  // Wait for the expected bytes, then compare count, markers and data
  task automatic drain(input logic [7:0] b[$]);
    int n;
    n = 0;
    foreach (b[i]) exp_q.push_back({i == 0, i == b.size() - 1, b[i]});
    while (rx_q.size() < exp_q.size() && n < LIM) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= LIM) timeout();
    repeat (20) @(posedge clk_in);
    chk(32'(rx_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && rx_q.size() > 0) begin
      chk(rx_q.pop_front(), exp_q.pop_front());
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [31:0] a, input int sz, input int nd);
    for (int i = 0; i < nd; i++) begin
      wd[i] = 8'($random(seed));
      sh[c == PTB_CODE_WR_FIXED ? {a[5:2], 2'(a + i)} : 6'(a + i)] = wd[i];
    end
    pkt(c, sz, a, nd, 8);
    drain('{c ^ PTB_RESP_FLIP, PTB_RSVD_BYTE, 8'(nd >> 8), 8'(nd)});
  endtask
  task automatic rd(input logic [7:0] c, input logic [31:0] a, input int sz);
    logic [7:0] r[$];
    for (int i = 0; i < sz; i++) begin
      r.push_back(sh[c == PTB_CODE_RD_FIXED ? {a[5:2], 2'(i)} : 6'(a + i)]);
    end
    pkt(c, sz, a, 0, 8);
    drain(r);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n0;
    int s;
    logic [31:0] a;
    foreach (sh[i]) sh[i] = 8'(i) ^ 8'h5A;
    repeat (20) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    wr(PTB_CODE_WR_INCR, 32'h10, 4, 4);
    rd(PTB_CODE_RD_INCR, 32'h10, 4);
    n0 = mem_i.acc_cnt;
    wr(PTB_CODE_WR_FIXED, 32'h20, 4, 4);
    chk(32'(mem_i.acc_cnt - n0), 32'h4);
    chk(mem_i.last_addr, 32'h20);
    rd(PTB_CODE_RD_FIXED, 32'h20, 8);
    n0 = mem_i.acc_cnt;
    wr(PTB_CODE_NOP, 32'h30, 0, 0);
    wr(8'h33, 32'h30, 0, 0);
    wr(8'hFF, 32'h30, 0, 0);
    chk(32'(mem_i.acc_cnt - n0), 32'h0);
    wr(PTB_CODE_WR_INCR, 32'h08, 8, 2);
    rd(PTB_CODE_RD_INCR, 32'h08, 4);
    pkt(PTB_CODE_WR_INCR, 4, 32'h00, 0, 3);
    wr(PTB_CODE_NOP, 32'h00, 0, 0);
    // Write cut inside its data by a new start of packet: no response for it
    sh[0] = 8'h00;
    for (int i = 0; i < 9; i++) put(i == 0 ? PTB_CODE_WR_INCR : 8'h00, i == 0, 1'b0);
    wr(PTB_CODE_NOP, 32'h00, 0, 0);
    rnd_on <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      a = 32'($unsigned($random(seed)) % 12) * 32'h4;
      s = 1 + $unsigned($random(seed)) % 8;
      wr(k[0] ? PTB_CODE_WR_FIXED : PTB_CODE_WR_INCR, a, s, s);
      rd(k[1] ? PTB_CODE_RD_FIXED : PTB_CODE_RD_INCR, a, s);
    end
    wrap_up();
  end
endmodule
